// ### hdl/acr_pkg.sv
// Constants, types and reset image of the decoder control register bank
package acr_pkg;

// =============================================================
// Bus addressing
localparam logic [6:0] DEV_ADDR = 7'h43;
localparam logic [6:0] A_VERSION = 7'h00;
localparam logic [6:0] A_IDENT = 7'h01;
localparam logic [6:0] A_PLL = 7'h05;
localparam logic [6:0] A_PLL_M = 7'h06;
localparam logic [6:0] A_PLL_N = 7'h07;
localparam logic [6:0] A_REQUEST_LINE_POLARITY = 7'h0c;
localparam logic [6:0] A_CLK_POL = 7'h0d;
localparam logic [6:0] A_ERROR = 7'h0f;
localparam logic [6:0] A_SOFT_RST = 7'h10;
localparam logic [6:0] A_PLAY = 7'h13;
localparam logic [6:0] A_MUTE = 7'h14;
localparam logic [6:0] A_CMD_INT = 7'h16;
localparam logic [6:0] A_HEAD_H = 7'h43;
localparam logic [6:0] A_HEAD_M = 7'h44;
localparam logic [6:0] A_HEAD_L = 7'h45;
localparam logic [6:0] A_SIDE0 = 7'h59;
localparam logic [6:0] A_FRAMES_L = 7'h67;
localparam logic [6:0] A_FRAMES_M = 7'h68;
localparam logic [6:0] A_FRAMES_H = 7'h69;
localparam logic [6:0] A_RATE = 7'h6a;
localparam logic [6:0] A_FW = 7'h71;
localparam logic [6:0] A_RUN = 7'h72;

// =============================================================
// Field positions
localparam int B_FRACTIONAL_VALUE_LOAD = 0;
localparam int B_XTAL_OUT_DIV = 1;
localparam int B_XTAL_CORE_DIV = 2;
localparam int B_VCO_DIS = 3;
localparam int B_SYS_TO_PAD = 4;
localparam int B_OUTPUT_CLOCK_PAD_EN = 5;
localparam int B_OSC_DIS = 6;
localparam int B_BUF_PIN = 7;
localparam int B_POL_INV = 2;
localparam int B_CMD = 0;

// =============================================================
// Values
localparam logic [7:0] ERR_NONE = 8'h00;
localparam logic [7:0] ERR_CRC = 8'h01;
localparam logic [7:0] ERR_MISSING = 8'h02;
localparam logic [7:0] PLAY_SOFT = 8'h01;
localparam logic [7:0] ZERO_BYTE = 8'h00;

typedef enum {S_IDLE, S_DEV, S_SUB, S_WR, S_ACK, S_RD, S_MACK} acr_bus_st_t;
typedef enum {D_IDLE, D_INIT, D_DECODE} acr_dec_st_t;

function automatic logic acr_writable(input logic [6:0] a);
    case (a)
        7'h05, 7'h06, 7'h07, 7'h0c, 7'h0d, 7'h13, 7'h14, 7'h16, 7'h18,
        7'h46, 7'h47, 7'h48, 7'h49, 7'h50, 7'h51, 7'h52, 7'h54, 7'h55,
        7'h56, 7'h61, 7'h63, 7'h64, 7'h65, 7'h72, 7'h77, 7'h78, 7'h79,
        7'h7a, 7'h7b, 7'h7c, 7'h7d: acr_writable = 1'b1;
        default: acr_writable = 1'b0;
    endcase
endfunction : acr_writable

function automatic logic acr_readable(input logic [6:0] a);
    case (a)
        7'h0f, 7'h43, 7'h44, 7'h45, 7'h59, 7'h5a, 7'h5b, 7'h5c, 7'h5d,
        7'h67, 7'h68, 7'h69, 7'h6a: acr_readable = 1'b1;
        default: acr_readable = acr_writable(a);
    endcase
endfunction : acr_readable

function automatic logic [7:0] acr_reset_value(input logic [6:0] a);
    case (a)
        7'h05: acr_reset_value = 8'h21;
        7'h06: acr_reset_value = 8'h0c;
        7'h0c: acr_reset_value = 8'h01;
        7'h0d: acr_reset_value = 8'h04;
        7'h13: acr_reset_value = 8'h01;
        7'h47: acr_reset_value = 8'hff;
        7'h49: acr_reset_value = 8'hff;
        7'h54: acr_reset_value = 8'h03;
        7'h55: acr_reset_value = 8'h21;
        7'h61: acr_reset_value = 8'h07;
        7'h64: acr_reset_value = 8'h46;
        7'h65: acr_reset_value = 8'h5b;
        default: acr_reset_value = 8'h00;
    endcase
endfunction : acr_reset_value

endpackage : acr_pkg

// ### hdl/acr_regs.sv
// Serial control bus slave and register bank of the audio decoder
`timescale 1ns/10ps

module acr_regs
    import acr_pkg::*;
#(
    parameter logic [7:0] REVISION = 8'h11,
    // Arbitrary identification value
    parameter logic [7:0] PART_ID = 8'h5a,
    parameter logic [7:0] FW_REV = 8'h01
)(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic data_request_raw_i,
    input wire logic header_valid_i,
    input wire logic [23:0] header_i,
    input wire logic side_data_valid_i,
    input wire logic [39:0] side_data_i,
    input wire logic [23:0] frame_count_i,
    input wire logic [7:0] mean_rate_i,
    input wire logic crc_fail_i,
    input wire logic data_missing_i,
    input wire logic first_samples_i,
    output logic fraction_load_o,
    output logic crystal_to_output_divider_o,
    output logic crystal_to_core_divider_o,
    output logic vco_disable_o,
    output logic system_clock_to_pad_o,
    output logic output_clock_pad_enable_o,
    output logic oscillator_out_disable_o,
    output logic buffered_clock_pin_enable_o,
    output logic [7:0] pll_multiplier_o,
    output logic [7:0] pll_input_divider_o,
    output logic data_request_o,
    output logic sample_on_falling_o,
    output logic soft_reset_o,
    output logic play_o,
    output logic mute_o,
    output logic decoder_idle_o,
    output logic decoder_init_o,
    output logic decoder_decode_o
);

// =============================================================
// State
typedef struct packed {
    logic [127:0][7:0] regs;
    acr_bus_st_t st;
    acr_bus_st_t ack_next;
    acr_dec_st_t dec;
    logic scl_q;
    logic sda_q;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic [6:0] sub;
    logic drv;
    logic m_ack;
    logic sda_oe;
    logic req_out;
    logic soft_pulse;
} acr_state_t;

acr_state_t r_r;
acr_state_t r_nxt;

function automatic acr_state_t reset_state();
    acr_state_t s;
    s = '0;
    for (int i = 0; i < 128; i++)
    begin
        s.regs[i] = acr_reset_value(7'(i));
    end
    s.st = S_IDLE;
    s.ack_next = S_IDLE;
    s.dec = D_IDLE;
    s.scl_q = 1'b1;
    s.sda_q = 1'b1;
    s.req_out = 1'b0;
    return s;
endfunction : reset_state

function automatic logic [7:0] rd_byte(input logic [6:0] a,
                                       input logic [127:0][7:0] regs);
    case (a)
        A_VERSION: rd_byte = REVISION;
        A_IDENT: rd_byte = PART_ID;
        A_FW: rd_byte = FW_REV;
        default: rd_byte = acr_readable(a) ? regs[a] : ZERO_BYTE;
    endcase
endfunction : rd_byte

// =============================================================
// Next state
always_comb
begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic wr;
    logic load;
    logic [7:0] byte_in;
    logic [7:0] rdat;
    r_nxt = r_r;
    rise = scl_i & ~r_r.scl_q;
    fall = ~scl_i & r_r.scl_q;
    start = scl_i & r_r.scl_q & r_r.sda_q & ~sda_i;
    stop = scl_i & r_r.scl_q & ~r_r.sda_q & sda_i;
    wr = 1'b0;
    load = 1'b0;
    byte_in = {r_r.shift[6:0], sda_i};
    rdat = rd_byte(r_r.sub, r_r.regs);
    r_nxt.scl_q = scl_i;
    r_nxt.sda_q = sda_i;
    r_nxt.soft_pulse = 1'b0;
    r_nxt.req_out = data_request_raw_i ^ r_r.regs[A_REQUEST_LINE_POLARITY][B_POL_INV];

    case (r_r.st)
        S_IDLE:
        begin
            r_nxt.sda_oe = 1'b0;
        end
        S_DEV, S_SUB, S_WR:
        begin
            if (rise)
            begin
                r_nxt.shift = byte_in;
                r_nxt.cnt = r_r.cnt + 3'd1;
                if (r_r.cnt == 3'd7)
                begin
                    r_nxt.st = S_ACK;
                    r_nxt.drv = 1'b0;
                    r_nxt.ack_next = S_WR;
                    if (r_r.st == S_DEV)
                    begin
                        if (byte_in[7:1] != DEV_ADDR)
                        begin
                            r_nxt.st = S_IDLE;
                        end
                        r_nxt.ack_next = byte_in[0] ? S_RD : S_SUB;
                    end
                    else if (r_r.st == S_SUB)
                    begin
                        r_nxt.sub = byte_in[6:0];
                    end
                    else
                    begin
                        wr = 1'b1;
                        r_nxt.sub = r_r.sub + 7'd1;
                    end
                end
            end
        end
        S_ACK:
        begin
            if (fall)
            begin
                if (!r_r.drv)
                begin
                    r_nxt.drv = 1'b1;
                    r_nxt.sda_oe = 1'b1;
                end
                else
                begin
                    r_nxt.drv = 1'b0;
                    r_nxt.sda_oe = 1'b0;
                    r_nxt.cnt = 3'd0;
                    r_nxt.st = r_r.ack_next;
                    load = (r_r.ack_next == S_RD);
                end
            end
        end
        S_RD:
        begin
            if (rise)
            begin
                r_nxt.cnt = r_r.cnt + 3'd1;
                if (r_r.cnt == 3'd7)
                begin
                    r_nxt.st = S_MACK;
                    r_nxt.drv = 1'b0;
                end
            end
            else if (fall)
            begin
                r_nxt.shift = {r_r.shift[6:0], 1'b0};
                r_nxt.sda_oe = ~r_r.shift[6];
            end
        end
        S_MACK:
        begin
            if (rise)
            begin
                r_nxt.m_ack = ~sda_i;
            end
            else if (fall)
            begin
                if (!r_r.drv)
                begin
                    r_nxt.drv = 1'b1;
                    r_nxt.sda_oe = 1'b0;
                end
                else
                begin
                    r_nxt.drv = 1'b0;
                    r_nxt.cnt = 3'd0;
                    r_nxt.st = r_r.m_ack ? S_RD : S_IDLE;
                    load = r_r.m_ack;
                end
            end
        end
        default:
        begin
            r_nxt.st = S_IDLE;
        end
    endcase

    if (load)
    begin
        r_nxt.shift = rdat;
        r_nxt.sda_oe = ~rdat[7];
        r_nxt.sub = r_r.sub + 7'd1;
    end
    if (start)
    begin
        r_nxt.st = S_DEV;
        r_nxt.cnt = 3'd0;
        r_nxt.drv = 1'b0;
        r_nxt.sda_oe = 1'b0;
    end
    else if (stop)
    begin
        r_nxt.st = S_IDLE;
        r_nxt.sda_oe = 1'b0;
    end

    // Status capture from the decoding core
    if (header_valid_i)
    begin
        r_nxt.regs[A_HEAD_H] = header_i[23:16];
        r_nxt.regs[A_HEAD_M] = header_i[15:8];
        r_nxt.regs[A_HEAD_L] = header_i[7:0];
    end
    if (side_data_valid_i)
    begin
        for (int i = 0; i < 5; i++)
        begin
            r_nxt.regs[A_SIDE0 + 7'(i)] = side_data_i[8*i +: 8];
        end
        r_nxt.regs[A_CMD_INT] = ZERO_BYTE;
    end
    r_nxt.regs[A_FRAMES_L] = frame_count_i[7:0];
    r_nxt.regs[A_FRAMES_M] = frame_count_i[15:8];
    r_nxt.regs[A_FRAMES_H] = frame_count_i[23:16];
    r_nxt.regs[A_RATE] = mean_rate_i;

    // Host write, soft reset and error flags
    if (wr && acr_writable(r_r.sub))
    begin
        r_nxt.regs[r_r.sub] = byte_in;
    end
    if (wr && r_r.sub == A_SOFT_RST)
    begin
        r_nxt.soft_pulse = 1'b1;
        r_nxt.regs[A_PLAY] = PLAY_SOFT;
        r_nxt.regs[A_MUTE] = ZERO_BYTE;
        r_nxt.regs[A_CMD_INT] = ZERO_BYTE;
        r_nxt.regs[A_RUN] = ZERO_BYTE;
        r_nxt.regs[A_ERROR] = ERR_NONE;
    end
    if (crc_fail_i)
    begin
        r_nxt.regs[A_ERROR] = ERR_CRC;
    end
    if (data_missing_i)
    begin
        r_nxt.regs[A_ERROR] = ERR_MISSING;
    end

    // Decoder state
    case (r_r.dec)
        D_IDLE:
        begin
            if (r_r.regs[A_RUN][B_CMD])
            begin
                r_nxt.dec = D_INIT;
            end
        end
        D_INIT:
        begin
            if (first_samples_i)
            begin
                r_nxt.dec = D_DECODE;
            end
        end
        D_DECODE:
        begin
            if (!r_r.regs[A_RUN][B_CMD])
            begin
                r_nxt.dec = D_IDLE;
            end
        end
        default:
        begin
            r_nxt.dec = D_IDLE;
        end
    endcase
    if (r_nxt.soft_pulse)
    begin
        r_nxt.dec = D_IDLE;
    end
end

always_ff @(posedge clk_sys_i)
begin
    if (reset_i)
    begin
        r_r <= reset_state();
    end
    else
    begin
        r_r <= r_nxt;
    end
end

// =============================================================
// Outputs
assign sda_o = 1'b0;
assign sda_oe_o = r_r.sda_oe;
assign fraction_load_o = r_r.regs[A_PLL][B_FRACTIONAL_VALUE_LOAD];
assign crystal_to_output_divider_o = r_r.regs[A_PLL][B_XTAL_OUT_DIV];
assign crystal_to_core_divider_o = r_r.regs[A_PLL][B_XTAL_CORE_DIV];
assign vco_disable_o = r_r.regs[A_PLL][B_VCO_DIS];
assign system_clock_to_pad_o = r_r.regs[A_PLL][B_SYS_TO_PAD];
assign output_clock_pad_enable_o = r_r.regs[A_PLL][B_OUTPUT_CLOCK_PAD_EN];
assign oscillator_out_disable_o = r_r.regs[A_PLL][B_OSC_DIS];
assign buffered_clock_pin_enable_o = r_r.regs[A_PLL][B_BUF_PIN];
assign pll_multiplier_o = r_r.regs[A_PLL_M];
assign pll_input_divider_o = r_r.regs[A_PLL_N];
assign data_request_o = r_r.req_out;
assign sample_on_falling_o = r_r.regs[A_CLK_POL][B_POL_INV];
assign soft_reset_o = r_r.soft_pulse;
assign play_o = r_r.regs[A_PLAY][B_CMD];
assign mute_o = r_r.regs[A_MUTE][B_CMD];
assign decoder_idle_o = (r_r.dec == D_IDLE);
assign decoder_init_o = (r_r.dec == D_INIT);
assign decoder_decode_o = (r_r.dec == D_DECODE);

// =============================================================
// Checks
logic load_seen;
assign load_seen = (r_nxt.st == S_RD) && (r_r.st != S_RD);

property p_request_line_polarity;
    @(posedge clk_sys_i) disable iff (reset_i)
    $stable(r_r.regs[A_REQUEST_LINE_POLARITY]) |=> (data_request_o ==
        ($past(data_request_raw_i) ^
        $past(r_r.regs[A_REQUEST_LINE_POLARITY][B_POL_INV])));
endproperty
a_request_line_polarity: assert property (p_request_line_polarity)
    else $error("request line polarity wrong");

property p_soft_idle;
    @(posedge clk_sys_i) disable iff (reset_i)
    soft_reset_o |-> decoder_idle_o && !r_r.regs[A_RUN][B_CMD] ##1
        decoder_idle_o;
endproperty
a_soft_idle: assert property (p_soft_idle)
    else $error("soft reset did not idle decoder");

property p_err_crc;
    @(posedge clk_sys_i) disable iff (reset_i)
    crc_fail_i && !data_missing_i |=> r_r.regs[A_ERROR] == ERR_CRC;
endproperty
a_err_crc: assert property (p_err_crc)
    else $error("crc error code not recorded");

property p_ident_load;
    @(posedge clk_sys_i) disable iff (reset_i)
    load_seen && r_r.sub == A_IDENT |=> r_r.shift == PART_ID;
endproperty
a_ident_load: assert property (p_ident_load)
    else $error("identification byte wrong");

property p_sub_inc;
    @(posedge clk_sys_i) disable iff (reset_i)
    r_r.st == S_WR && scl_i && !r_r.scl_q && r_r.cnt == 3'd7 |=>
        r_r.sub == $past(r_r.sub) + 7'd1;
endproperty
a_sub_inc: assert property (p_sub_inc)
    else $error("sub-address did not advance");

property p_dev_nack;
    @(posedge clk_sys_i) disable iff (reset_i)
    r_r.st == S_DEV && scl_i && !r_r.scl_q && r_r.cnt == 3'd7 &&
        r_r.shift[6:0] != DEV_ADDR |=> !sda_oe_o [*8];
endproperty
a_dev_nack: assert property (p_dev_nack)
    else $error("answered a foreign address");

property p_init_decode;
    @(posedge clk_sys_i) disable iff (reset_i)
    decoder_init_o && first_samples_i && !soft_reset_o |=>
        decoder_decode_o || soft_reset_o;
endproperty
a_init_decode: assert property (p_init_decode)
    else $error("init did not move to decode");

property p_pll_reset;
    @(posedge clk_sys_i)
    reset_i |=> output_clock_pad_enable_o && fraction_load_o &&
        !vco_disable_o && !buffered_clock_pin_enable_o;
endproperty
a_pll_reset: assert property (p_pll_reset)
    else $error("clock control reset value wrong");

endmodule : acr_regs

// ### verif/acr_host.sv
// Serial control bus master model that stands in for the host
`timescale 1ns/10ps

module acr_host
    import acr_pkg::*;
(
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);

// =============================================================
// Bus phases, each at least two system clocks long
initial
begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
end

task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
    #1;
endtask : hold

task automatic wbit(input logic b);
    sda_low_o = ~b;
    hold(4);
    scl_o = 1'b1;
    hold(4);
    scl_o = 1'b0;
    hold(2);
endtask : wbit

task automatic rbit(output logic b);
    sda_low_o = 1'b0;
    hold(4);
    scl_o = 1'b1;
    hold(2);
    b = sda_i;
    hold(2);
    scl_o = 1'b0;
    hold(2);
endtask : rbit

// Also serves as repeated start: data is released while clock is low
task automatic start_c();
    sda_low_o = 1'b0;
    hold(4);
    scl_o = 1'b1;
    hold(4);
    sda_low_o = 1'b1;
    hold(4);
    scl_o = 1'b0;
    hold(2);
endtask : start_c

task automatic stop_c();
    sda_low_o = 1'b1;
    hold(4);
    scl_o = 1'b1;
    hold(4);
    sda_low_o = 1'b0;
    hold(4);
endtask : stop_c

// =============================================================
// Whole bytes, MSB first, with the ninth clock
task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(a);
    ack = ~a;
endtask : wbyte

task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(last);
endtask : rbyte

task automatic send_addr(input logic rd, output logic ack);
    wbyte({DEV_ADDR, rd}, ack);
endtask : send_addr

endmodule : acr_host

// ### verif/tb_top.sv
// Self-checking bench of the decoder control register bank
`timescale 1ns/10ps

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module tb_top
    import acr_pkg::*;
;
localparam logic [7:0] T_REV = 8'h3c;
// Arbitrary identification value
localparam logic [7:0] T_ID = 8'h96;
localparam logic [7:0] T_FW = 8'h27;
localparam int N_ROWS = 16;

logic clk_sys_i = 1'b0;
logic reset_i = 1'b1;
logic scl, sda, host_low, sda_o, sda_oe_o, raw_req = 1'b0;
logic hdr_v = 1'b0, crc = 1'b0, miss = 1'b0, first = 1'b0;
logic [23:0] hdr = 24'h00_0000;
logic sdv = 1'b0;
logic [39:0] sdat = 40'h00_0000_0000;
logic [23:0] fcnt = 24'h03_0201;
logic [7:0] mrate = 8'h5e;
logic [7:0] pll, mult, ndiv;
logic dreq, fall, srst, play, mute, d_idle, d_init, d_dec;
logic [7:0] d, s, r, w, e;
logic [23:0] v;
logic ok;
int failures = 0;
int n_tests = 0;
int sr_cnt = 0;
logic [31:0] rows [N_ROWS] = '{
    {8'h00, T_REV, 8'h55, T_REV}, {8'h01, T_ID, 8'h00, T_ID},
    {8'h05, 8'h21, 8'ha5, 8'ha5}, {8'h06, 8'h0c, 8'h13, 8'h13},
    {8'h07, 8'h00, 8'h0a, 8'h0a}, {8'h0c, 8'h01, 8'h05, 8'h05},
    {8'h0d, 8'h04, 8'h00, 8'h00}, {8'h0f, 8'h00, 8'h7e, 8'h00},
    {8'h43, 8'h00, 8'h11, 8'h00}, {8'h47, 8'hff, 8'h3c, 8'h3c},
    {8'h61, 8'h07, 8'h19, 8'h19}, {8'h64, 8'h46, 8'h00, 8'h00},
    {8'h65, 8'h5b, 8'h77, 8'h77}, {8'h67, 8'h01, 8'hff, 8'h01},
    {8'h71, T_FW, 8'h12, T_FW}, {8'h7d, 8'h00, 8'h99, 8'h99}};

always #4 clk_sys_i = ~clk_sys_i;
assign sda = ~(host_low | (sda_oe_o & ~sda_o));
always @(posedge clk_sys_i) if (srst === 1'b1) sr_cnt++;

acr_regs #(.REVISION(T_REV), .PART_ID(T_ID), .FW_REV(T_FW)) u_acr_regs (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .data_request_raw_i(raw_req),
    .header_valid_i(hdr_v), .header_i(hdr), .side_data_valid_i(sdv),
    .side_data_i(sdat), .frame_count_i(fcnt),
    .mean_rate_i(mrate), .crc_fail_i(crc), .data_missing_i(miss),
    .first_samples_i(first), .fraction_load_o(pll[0]),
    .crystal_to_output_divider_o(pll[1]),
    .crystal_to_core_divider_o(pll[2]), .vco_disable_o(pll[3]),
    .system_clock_to_pad_o(pll[4]), .output_clock_pad_enable_o(pll[5]),
    .oscillator_out_disable_o(pll[6]),
    .buffered_clock_pin_enable_o(pll[7]), .pll_multiplier_o(mult),
    .pll_input_divider_o(ndiv), .data_request_o(dreq),
    .sample_on_falling_o(fall), .soft_reset_o(srst), .play_o(play),
    .mute_o(mute), .decoder_idle_o(d_idle), .decoder_init_o(d_init),
    .decoder_decode_o(d_dec));

acr_host u_acr_host (.clk_i(clk_sys_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(host_low));

// =============================================================
// Bus transfers
task automatic reg_wr(input logic [7:0] sub, input logic [7:0] dat);
    logic a0, a1, a2;
    u_acr_host.start_c();
    u_acr_host.send_addr(1'b0, a0);
    u_acr_host.wbyte(sub, a1);
    u_acr_host.wbyte(dat, a2);
    u_acr_host.stop_c();
    `CHK(a0 & a1 & a2, 1'b1)
endtask : reg_wr

task automatic reg_rd(input logic [7:0] sub, input int n,
    output logic [23:0] val);
    logic a0, a1, a2;
    logic [7:0] b;
    u_acr_host.start_c();
    u_acr_host.send_addr(1'b0, a0);
    u_acr_host.wbyte(sub, a1);
    u_acr_host.start_c();
    u_acr_host.send_addr(1'b1, a2);
    for (int i = 0; i < n; i++)
    begin
        u_acr_host.rbyte(i == n - 1, b);
        val = {val[15:0], b};
    end
    u_acr_host.stop_c();
    `CHK(a0 & a1 & a2, 1'b1)
endtask : reg_rd

task automatic pulse(ref logic sig);
    sig = 1'b1;
    u_acr_host.hold(1);
    sig = 1'b0;
    u_acr_host.hold(2);
endtask : pulse

task automatic end_of_test();
    if (failures == 0 && n_tests > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask : end_of_test

initial
begin
    #400_000;
    failures++;
    end_of_test();
end

// =============================================================
// Main sequence
initial
begin
    u_acr_host.hold(8);
    reset_i = 1'b0;
    u_acr_host.hold(2);
    `CHK({pll, mult, ndiv}, 24'h21_0c00)
    `CHK({fall, play, mute, d_idle}, 4'hd)
    for (int i = 0; i < N_ROWS; i++)
    begin
        {s, r, w, e} = rows[i];
        reg_rd(s, 1, v);
        `CHK(v[7:0], r)
        // Read-only rows hold a write value unlike their expectation
        if (w == e)
            reg_wr(s, w);
        reg_rd(s, 1, v);
        `CHK(v[7:0], e)
    end
    `CHK({mult, ndiv, fall}, {8'h13, 8'h0a, 1'b0})
    for (int i = 0; i < 8; i++)
    begin
        reg_wr(8'h05, 8'h01 << i);
        `CHK(pll, 8'h01 << i)
    end
    raw_req = 1'b1;
    u_acr_host.hold(3);
    `CHK(dreq, 1'b0)
    reg_wr(8'h0c, 8'h01);
    `CHK(dreq, 1'b1)
    u_acr_host.start_c();
    u_acr_host.wbyte(8'h88, ok);
    u_acr_host.stop_c();
    `CHK(ok, 1'b0)
    u_acr_host.start_c();
    u_acr_host.send_addr(1'b0, ok);
    u_acr_host.wbyte(8'h77, ok);
    u_acr_host.wbyte(8'ha1, ok);
    u_acr_host.wbyte(8'hb2, ok);
    u_acr_host.wbyte(8'hc3, ok);
    u_acr_host.stop_c();
    reg_rd(8'h77, 3, v);
    `CHK(v, 24'ha1_b2c3)
    hdr = 24'hab_cdef;
    pulse(hdr_v);
    reg_rd(8'h43, 3, v);
    `CHK(v, 24'hab_cdef)
    reg_wr(8'h16, 8'h01);
    sdat = 40'h51_4233_2415;
    pulse(sdv);
    reg_rd(8'h59, 3, v);
    `CHK(v, 24'h15_2433)
    reg_rd(8'h5c, 2, v);
    `CHK(v[15:0], 16'h4251)
    reg_rd(8'h16, 1, v);
    `CHK(v[7:0], 8'h00)
    fcnt = 24'h0a_0b0c;
    mrate = 8'h3d;
    u_acr_host.hold(2);
    reg_rd(8'h67, 3, v);
    `CHK(v, 24'h0c_0b0a)
    reg_rd(8'h6a, 1, v);
    `CHK(v[7:0], 8'h3d)
    pulse(crc);
    reg_rd(8'h0f, 1, v);
    `CHK(v[7:0], ERR_CRC)
    miss = 1'b1;
    pulse(crc);
    miss = 1'b0;
    reg_rd(8'h0f, 1, v);
    `CHK(v[7:0], ERR_MISSING)
    reg_wr(8'h13, 8'h00);
    reg_wr(8'h72, 8'h01);
    `CHK({d_idle, d_init, d_dec}, 3'b010)
    pulse(first);
    `CHK({d_idle, d_init, d_dec}, 3'b001)
    reg_wr(8'h10, 8'h5a);
    `CHK({sr_cnt[7:0], d_idle, play}, 10'h007)
    reg_rd(8'h72, 1, v);
    `CHK(v[7:0], 8'h00)
    reg_rd(8'h0f, 1, v);
    `CHK(v[7:0], ERR_NONE)
    reg_rd(8'h01, 1, v);
    `CHK(v[7:0], T_ID)
    reset_i = 1'b1;
    u_acr_host.hold(3);
    reset_i = 1'b0;
    u_acr_host.hold(2);
    `CHK({pll, mult, ndiv}, 24'h21_0c00)
    reg_rd(8'h00, 2, v);
    `CHK(v[15:0], {T_REV, T_ID})
    end_of_test();
end

endmodule : tb_top
